// ### test/dscl_loader_sva.sv
/*
 * Checker for the switch configuration loader: capture order, hold of the
 * decoded settings and bus answer release.
 * Assumes it is bound to dscl_loader and sees only its ports.
 */
`timescale 1ns/1ps

module dscl_loader_chk (
  // Clock and reset
  input wire MCLK,
  input wire NRST,
  // Bus answers
  input wire BVALID,
  input wire BREADY,
  input wire RVALID,
  input wire RREADY,
  // Switch link
  input wire SW_CLK,
  input wire SW_LOAD_N,
  // Settings and pins
  input wire [31:0] DO_PINS,
  input wire CFG_VALID,
  input wire INPUT_FILTER_ENABLE,
  input wire OUTPUT_HALF_SELECT,
  input wire [5:0] OUTPUT_SOURCE_STATION,
  input wire [5:0] OWN_STATION_ADDRESS,
  input wire RATE_SELECT_HIGH,
  input wire RATE_SELECT_LOW,
  input wire RATE_INVALID
);
  reg [4:0] rise_q;
  reg sclk_q;
  wire [13:0] sets = {INPUT_FILTER_ENABLE, OUTPUT_HALF_SELECT,
    OUTPUT_SOURCE_STATION, OWN_STATION_ADDRESS};

  // ****************************************
  // Serial clock rise counter
  // ****************************************
  // Counts since reset, so a word longer or shorter than 16 bits shows
  always @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      rise_q <= 5'h00;
      sclk_q <= 1'b0;
    end else begin
      sclk_q <= SW_CLK;
      if (SW_CLK && !sclk_q) rise_q <= rise_q + 5'h01;
    end
  end

  default clocking @(posedge MCLK); endclocking
  default disable iff (!NRST);

  // ****************************************
  // Properties
  // ****************************************
  cfg_stays_a:
    assert property (CFG_VALID |=> CFG_VALID) else $error("capture dropped");
  set_stable_a:
    assert property ($past(CFG_VALID) && CFG_VALID |-> $stable(sets)
      && $stable({RATE_SELECT_HIGH, RATE_SELECT_LOW}))
      else $error("setting moved after capture");
  pre_zero_a:
    assert property (!CFG_VALID |-> sets == 14'h0000 && DO_PINS == 32'h0)
      else $error("setting used before capture");
  bit_count_a:
    assert property ($rose(CFG_VALID) |-> rise_q == 5'h10)
      else $error("word length not 16 clocks");
  clk_after_load_a:
    assert property ($rose(SW_CLK) |-> SW_LOAD_N && !CFG_VALID)
      else $error("serial clock out of frame");
  rate_bad_a:
    assert property (RATE_INVALID == (RATE_SELECT_HIGH && RATE_SELECT_LOW))
      else $error("rate flag wrong");
  b_done_a:
    assert property (BVALID && BREADY |=> !BVALID) else $error("b kept");
  r_done_a:
    assert property (RVALID && RREADY |=> !RVALID) else $error("r kept");
endmodule

bind dscl_loader dscl_loader_chk i_dscl_loader_chk (.MCLK(MCLK),
  .NRST(NRST), .BVALID(BVALID), .BREADY(BREADY), .RVALID(RVALID),
  .RREADY(RREADY), .SW_CLK(SW_CLK), .SW_LOAD_N(SW_LOAD_N),
  .DO_PINS(DO_PINS), .CFG_VALID(CFG_VALID),
  .INPUT_FILTER_ENABLE(INPUT_FILTER_ENABLE),
  .OUTPUT_HALF_SELECT(OUTPUT_HALF_SELECT),
  .OUTPUT_SOURCE_STATION(OUTPUT_SOURCE_STATION),
  .OWN_STATION_ADDRESS(OWN_STATION_ADDRESS),
  .RATE_SELECT_HIGH(RATE_SELECT_HIGH), .RATE_SELECT_LOW(RATE_SELECT_LOW),
  .RATE_INVALID(RATE_INVALID));

// ### test/dscl_sw_model.sv
/*
 * Behavioural switch-reader chip with two 8-way banks.
 * Assumes the loader's load pulse and serial clock; pulled up when idle.
 */
`timescale 1ns/1ps

module dscl_sw_model (
  // Serial link
  input wire sw_clk,
  input wire sw_load_n,
  output wire sw_data,
  // Switch positions, 1 = closed
  input wire [15:0] switches
);
  reg [15:0] held_q;
  integer idx_q = -1;

  // Load latches both banks, each clock rise moves on one bit
  always @(posedge sw_clk or negedge sw_load_n) begin
    if (!sw_load_n) begin
      held_q <= switches; // Binary banks, no decimal coding
      idx_q <= 15;
    end else if (idx_q >= 0) begin
      idx_q <= idx_q - 1;
    end
  end

  // Closed switch pulls low; pull-up once the word is out
  assign sw_data = (idx_q >= 0) ? ~held_q[idx_q] : 1'b1;
endmodule

// ### test/tb_dscl_loader.sv
/*
 * Testbench for the loader: table of switch words, then bus corner cases.
 * Assumes the switch model file and the register header on the path.
 */
`timescale 1ns/1ps
`include "dscl_regs.vh"

module tb_dscl_loader;
  typedef struct packed {
    logic [15:0] w;
    logic f, h;
    logic [5:0] s, o;
    logic [1:0] rt;
    logic [3:0] mb;
  } dscl_row_t;
  logic MCLK = 1'b0, NRST = 1'b0;
  logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
  logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0;
  logic ARVALID = 1'b0, RREADY = 1'b0;
  logic [31:0] WDATA = 32'h0, DI_PINS = 32'h0, rd, ev;
  logic [3:0] WSTRB = 4'hF;
  logic [15:0] sw_word = 16'h0000;
  logic [1:0] rsp;
  wire AWREADY, WREADY, BVALID, ARREADY, RVALID, SW_DATA, SW_CLK, SW_LOAD_N;
  wire CFG_VALID, fe, hs, rh, rl, ri;
  wire [1:0] BRESP, RRESP;
  wire [31:0] RDATA, DO_PINS;
  wire [5:0] src, own;
  integer errors = 0, cmp_count = 0;
  dscl_row_t rows[4];

  // Short serial half period keeps each capture near 70 cycles
  dscl_loader #(.SCLK_HALF(2)) i_dscl_loader (.MCLK(MCLK), .NRST(NRST),
    .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY), .WDATA(WDATA),
    .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
    .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID),
    .RREADY(RREADY), .SW_DATA(SW_DATA), .SW_CLK(SW_CLK),
    .SW_LOAD_N(SW_LOAD_N), .DI_PINS(DI_PINS), .DO_PINS(DO_PINS),
    .CFG_VALID(CFG_VALID), .INPUT_FILTER_ENABLE(fe),
    .OUTPUT_HALF_SELECT(hs), .OUTPUT_SOURCE_STATION(src),
    .OWN_STATION_ADDRESS(own), .RATE_SELECT_HIGH(rh),
    .RATE_SELECT_LOW(rl), .RATE_INVALID(ri));
  dscl_sw_model i_dscl_sw_model (.sw_clk(SW_CLK), .sw_load_n(SW_LOAD_N),
    .sw_data(SW_DATA), .switches(sw_word));

  // ****************************************
  // Clock, watchdog and shared tasks
  // ****************************************
  always #5 MCLK = ~MCLK;

  initial begin
    repeat (5000) @(posedge MCLK);
    errors++;
    complete_run;
  end

  task complete_run;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk(input string n, input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", n, exp, got);
    end
  endtask

  // Write: address and data together, each released once taken
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge MCLK);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    do begin
      @(posedge MCLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
    end while (BVALID !== 1'b1);
    rsp = BRESP;
    BREADY <= 1'b0;
  endtask

  task rdr(input logic [7:0] a);
    @(posedge MCLK);
    ARADDR <= a;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    do begin
      @(posedge MCLK);
      if (ARREADY) ARVALID <= 1'b0;
    end while (RVALID !== 1'b1);
    rd = RDATA;
    rsp = RRESP;
    RREADY <= 1'b0;
  endtask

  // Reset with new switches, then wait for the capture
  task boot(input logic [15:0] w);
    @(posedge MCLK);
    NRST <= 1'b0;
    sw_word <= w;
    repeat (16) @(posedge MCLK);
    NRST <= 1'b1;
    repeat (400) begin
      @(posedge MCLK);
      if (CFG_VALID === 1'b1) break;
    end
    chk("cfg valid", CFG_VALID, 1'b1);
  endtask

  task settings(input dscl_row_t r);
    chk("filter", fe, r.f);
    chk("half", hs, r.h);
    chk("source", src, r.s);
    chk("own", own, r.o);
    chk("rate bits", {rh, rl}, r.rt);
    chk("rate bad", ri, &r.rt);
    rdr(`DSCL_REG_CFG);
    chk("cfg word", rd, r.w);
    rdr(`DSCL_REG_STATUS);
    chk("rate code", rd[7:4], r.mb);
    chk("status flags", rd[2:0], {&r.rt, 1'b0, 1'b1});
    rdr(`DSCL_REG_OWN_HI);
    chk("block hi", rd[15:8], {r.f, r.s, r.h});
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rows = '{'{16'h0000, 0, 0, 6'h00, 6'h00, 2'h0, `DSCL_RATE_12},
      '{16'hBF7F, 1, 0, 6'h3F, 6'h3F, 2'h1, `DSCL_RATE_6},
      '{16'h41A5, 0, 1, 6'h01, 6'h25, 2'h2, `DSCL_RATE_3},
      '{16'h2AC0, 0, 0, 6'h2A, 6'h00, 2'h3, `DSCL_RATE_NONE}};
    foreach (rows[i]) begin
      boot(rows[i].w);
      settings(rows[i]);
      DI_PINS <= {16'hA5C3, rows[i].w};
      wr(`DSCL_REG_SRC_LO, 32'h1357_9BDF);
      wr(`DSCL_REG_SRC_HI, 32'h2468_ACE0);
      @(posedge MCLK);
      ev = rows[i].h ? 32'h2468_ACE0 : 32'h1357_9BDF;
      chk("do pins", DO_PINS, ev);
      rdr(`DSCL_REG_OWN_LO);
      chk("own lo", rd, {16'hA5C3, rows[i].w});
      // One-cycle glitch: the read is timed to catch it in the own block
      ev = {16'hA5C3, rows[i].w};
      @(posedge MCLK);
      DI_PINS <= ~ev;
      @(posedge MCLK);
      DI_PINS <= ev;
      rdr(`DSCL_REG_OWN_LO);
      chk("filter glitch", rd, rows[i].f ? ev : ~ev);
    end
    // Unmapped place answers with an error and reads zero
    wr(8'hF0, 32'hFFFF_FFFF);
    chk("unmapped wr", rsp, `DSCL_RESP_SLVERR);
    rdr(8'hF0);
    chk("unmapped rd", rsp, `DSCL_RESP_SLVERR);
    chk("unmapped data", rd, 32'h0);
    // Read-only word ignores writes; moved switches are not re-read
    wr(`DSCL_REG_CFG, 32'h0000_FFFF);
    chk("ro wr", rsp, `DSCL_RESP_OKAY);
    sw_word <= 16'hFFFF;
    repeat (100) @(posedge MCLK);
    settings(rows[3]);
    // Byte lanes: only lane 0 of the source image takes the write
    WSTRB <= 4'h1;
    wr(`DSCL_REG_SRC_LO, 32'hFFFF_FFFF);
    WSTRB <= 4'hF;
    rdr(`DSCL_REG_SRC_LO);
    chk("lane wr", rd, 32'h1357_9BFF);
    // Reset in mid-run clears the settings, then a fresh read follows
    @(posedge MCLK);
    NRST <= 1'b0;
    @(posedge MCLK);
    chk("rst valid", CFG_VALID, 1'b0);
    chk("rst pins", DO_PINS, 32'h0);
    chk("rst src", src, 6'h00);
    chk("rst idle", {SW_LOAD_N, SW_CLK}, 2'b10);
    NRST <= 1'b1;
    repeat (2) @(posedge MCLK);
    chk("load pulse", SW_LOAD_N, 1'b0);
    chk("rst ready", AWREADY, 1'b1);
    boot(16'hFFFF);
    rows[0] = '{16'hFFFF, 1, 1, 6'h3F, 6'h3F, 2'h3, `DSCL_RATE_NONE};
    settings(rows[0]);
    complete_run;
  end
endmodule

// ### verilog/dscl_loader.v
/*
 * DIP switch configuration loader with an AXI4-Lite register slave.
 * Reads the 16-bit switch word once after reset, decodes the settings,
 * filters the input pins, selects the output half and shows the station's
 * own memory block image.
 * Assumes a single 100 MHz clock and inputs synchronous to it.
 */
// Behaviour
// - Read 16-bit switch word serially after reset.
// - Closed switch, low level, reads as one.
// - Filter enable bit turns input filtering on.
// - Half select picks lower or upper 32 bits.
// - First bank bits 1-6 give source station.
// - Second bank bits 1-6 give own address.
// - Rate bits choose 12, 6 or 3 Mbps.
// - Copy settings into memory block bits 47-40.
// - Publish inputs in block of own address.
`timescale 1ns/1ps
`include "dscl_regs.vh"

module dscl_loader #(
  parameter SCLK_HALF = `DSCL_SCLK_HALF_CYC
) (
  // Clock and reset
  input wire MCLK,
  input wire NRST,
  // AXI4-Lite write address and data
  input wire [`DSCL_ADDR_W-1:0] AWADDR,
  input wire AWVALID,
  output reg AWREADY,
  input wire [31:0] WDATA,
  input wire [3:0] WSTRB,
  input wire WVALID,
  output reg WREADY,
  // AXI4-Lite write response
  output reg [1:0] BRESP,
  output reg BVALID,
  input wire BREADY,
  // AXI4-Lite read
  input wire [`DSCL_ADDR_W-1:0] ARADDR,
  input wire ARVALID,
  output reg ARREADY,
  output reg [31:0] RDATA,
  output reg [1:0] RRESP,
  output reg RVALID,
  input wire RREADY,
  // Switch reader pins
  input wire SW_DATA,
  output wire SW_CLK,
  output wire SW_LOAD_N,
  // Station pins
  input wire [31:0] DI_PINS,
  output reg [31:0] DO_PINS,
  // Decoded settings
  output reg CFG_VALID,
  output reg INPUT_FILTER_ENABLE,
  output reg OUTPUT_HALF_SELECT,
  output reg [5:0] OUTPUT_SOURCE_STATION,
  output reg [5:0] OWN_STATION_ADDRESS,
  output reg RATE_SELECT_HIGH,
  output reg RATE_SELECT_LOW,
  output reg RATE_INVALID
);

  wire [15:0] sh_word;
  wire sh_done, sh_busy;
  reg [31:0] src_lo_q, src_hi_q;
  reg [31:0] di_s1_q, di_s2_q, di_f_q, di_f_d;
  reg [31:0] rd_d;
  reg rd_ok;
  reg aw_have_q;
  reg w_have_q;
  reg [`DSCL_ADDR_W-1:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  wire aw_take, w_take, ar_take, wr_fire;
  wire aw_have_d, w_have_d, bvalid_d, rvalid_d;

  // Network rate in Mbps from the two rate bits; both set is no rate
  function [3:0] dscl_rate;
    input hi;
    input lo;
    begin
      case ({hi, lo})
        2'b00: dscl_rate = `DSCL_RATE_12;
        2'b01: dscl_rate = `DSCL_RATE_6;
        2'b10: dscl_rate = `DSCL_RATE_3;
        default: dscl_rate = `DSCL_RATE_NONE;
      endcase
    end
  endfunction

  // ****************************************************************
  // Serial switch read
  // ****************************************************************
  dscl_shifter #(
    .WIDTH(`DSCL_CFG_WIDTH),
    .HALF(SCLK_HALF)
  ) i_dscl_shifter (
    .mclk(MCLK),
    .nrst(NRST),
    .sw_data(SW_DATA),
    .sw_clk_q(SW_CLK),
    .sw_load_n_q(SW_LOAD_N),
    .word_q(sh_word),
    .done_q(sh_done),
    .busy_q(sh_busy)
  );

  // ****************************************************************
  // Capture and decode of the settings
  // ****************************************************************
  // Taken once; later shifter activity cannot disturb the settings
  always @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      CFG_VALID <= 1'b0;
      INPUT_FILTER_ENABLE <= 1'b0;
      OUTPUT_HALF_SELECT <= 1'b0;
      OUTPUT_SOURCE_STATION <= 6'h00;
      OWN_STATION_ADDRESS <= 6'h00;
      RATE_SELECT_HIGH <= 1'b0;
      RATE_SELECT_LOW <= 1'b0;
      RATE_INVALID <= 1'b0;
    end else if (sh_done && !CFG_VALID) begin
      CFG_VALID <= 1'b1;
      INPUT_FILTER_ENABLE <= sh_word[`DSCL_F_FILTER];
      OUTPUT_HALF_SELECT <= sh_word[`DSCL_F_HALF];
      OUTPUT_SOURCE_STATION <=
        sh_word[`DSCL_F_SRC_MSB:`DSCL_F_SRC_LSB];
      OWN_STATION_ADDRESS <=
        sh_word[`DSCL_F_OWN_MSB:`DSCL_F_OWN_LSB];
      RATE_SELECT_HIGH <= sh_word[`DSCL_F_RATE_HI];
      RATE_SELECT_LOW <= sh_word[`DSCL_F_RATE_LO];
      // Forbidden setting is flagged only; the rate reads as none
      RATE_INVALID <= sh_word[`DSCL_F_RATE_HI] & sh_word[`DSCL_F_RATE_LO];
    end
  end

  // ****************************************************************
  // Input filter and output half select
  // ****************************************************************
  // With the filter on, a bit follows the pin only after two equal samples, otherwise holds; with it off, it follows the first sample
  always @* begin
    if (INPUT_FILTER_ENABLE) begin
      di_f_d = ((di_s1_q ~^ di_s2_q) & di_s2_q) |
               ((di_s1_q ^ di_s2_q) & di_f_q);
    end else begin
      di_f_d = di_s1_q;
    end
  end

  // Outputs stay low until the settings are known
  always @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      di_s1_q <= 32'h00000000;
      di_s2_q <= 32'h00000000;
      di_f_q <= 32'h00000000;
      DO_PINS <= 32'h00000000;
    end else begin
      di_s1_q <= DI_PINS;
      di_s2_q <= di_s1_q;
      di_f_q <= CFG_VALID ? di_f_d : 32'h00000000;
      if (!CFG_VALID) begin
        DO_PINS <= 32'h00000000;
      end else if (OUTPUT_HALF_SELECT) begin
        DO_PINS <= src_hi_q;
      end else begin
        DO_PINS <= src_lo_q;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite write channel
  // ****************************************************************
  assign aw_take = AWVALID & AWREADY;
  assign w_take = WVALID & WREADY;
  assign wr_fire = aw_have_q & w_have_q & ~BVALID;
  assign aw_have_d = aw_take | (aw_have_q & ~wr_fire);
  assign w_have_d = w_take | (w_have_q & ~wr_fire);
  assign bvalid_d = wr_fire | (BVALID & ~BREADY);

  // Address and data are taken in either order; one write at a time
  always @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= {`DSCL_ADDR_W{1'b0}};
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      AWREADY <= 1'b0;
      WREADY <= 1'b0;
      BVALID <= 1'b0;
      BRESP <= `DSCL_RESP_OKAY;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      AWREADY <= ~aw_have_d & ~bvalid_d;
      WREADY <= ~w_have_d & ~bvalid_d;
      BVALID <= bvalid_d;
      if (aw_take) begin
        awaddr_q <= AWADDR;
      end
      if (w_take) begin
        wdata_q <= WDATA;
        wstrb_q <= WSTRB;
      end
      if (wr_fire) begin
        case (awaddr_q)
          `DSCL_REG_CFG, `DSCL_REG_STATUS, `DSCL_REG_SRC_LO,
          `DSCL_REG_SRC_HI, `DSCL_REG_OWN_LO, `DSCL_REG_OWN_HI:
            BRESP <= `DSCL_RESP_OKAY;
          default: BRESP <= `DSCL_RESP_SLVERR;
        endcase
      end
    end
  end

  // Source block image, written per byte lane
  genvar gb;
  generate
    for (gb = 0; gb < 4; gb = gb + 1) begin : g_lane
      always @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
          src_lo_q[gb*8+7:gb*8] <= 8'h00;
          src_hi_q[gb*8+7:gb*8] <= 8'h00;
        end else if (wr_fire && wstrb_q[gb]) begin
          if (awaddr_q == `DSCL_REG_SRC_LO) begin
            src_lo_q[gb*8+7:gb*8] <= wdata_q[gb*8+7:gb*8];
          end
          if (awaddr_q == `DSCL_REG_SRC_HI) begin
            src_hi_q[gb*8+7:gb*8] <= wdata_q[gb*8+7:gb*8];
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // AXI4-Lite read channel
  // ****************************************************************
  assign ar_take = ARVALID & ARREADY;
  assign rvalid_d = ar_take | (RVALID & ~RREADY);

  // Read decode; unmapped offsets read zero with an error response
  always @* begin
    rd_d = 32'h00000000;
    rd_ok = 1'b1;
    case (ARADDR)
      `DSCL_REG_CFG: rd_d[15:0] = CFG_VALID ? sh_word : 16'h0000;
      `DSCL_REG_STATUS: begin
        rd_d[`DSCL_ST_DONE] = CFG_VALID;
        rd_d[`DSCL_ST_BUSY] = sh_busy;
        rd_d[`DSCL_ST_RATE_INV] = RATE_INVALID;
        rd_d[`DSCL_ST_RATE_LSB+3:`DSCL_ST_RATE_LSB] =
          CFG_VALID ? dscl_rate(RATE_SELECT_HIGH, RATE_SELECT_LOW)
                    : `DSCL_RATE_NONE;
      end
      `DSCL_REG_SRC_LO: rd_d = src_lo_q;
      `DSCL_REG_SRC_HI: rd_d = src_hi_q;
      `DSCL_REG_OWN_LO: rd_d = di_f_q;
      `DSCL_REG_OWN_HI: begin
        rd_d[`DSCL_MB_FILTER] = INPUT_FILTER_ENABLE;
        rd_d[`DSCL_MB_SRC_MSB:`DSCL_MB_SRC_LSB] = OUTPUT_SOURCE_STATION;
        rd_d[`DSCL_MB_HALF] = OUTPUT_HALF_SELECT;
      end
      default: rd_ok = 1'b0;
    endcase
  end

  // Data is latched at the address handshake and held until taken
  always @(posedge MCLK or negedge NRST) begin
    if (!NRST) begin
      ARREADY <= 1'b0;
      RVALID <= 1'b0;
      RDATA <= 32'h00000000;
      RRESP <= `DSCL_RESP_OKAY;
    end else begin
      ARREADY <= ~rvalid_d;
      RVALID <= rvalid_d;
      if (ar_take) begin
        RDATA <= rd_d;
        RRESP <= rd_ok ? `DSCL_RESP_OKAY : `DSCL_RESP_SLVERR;
      end
    end
  end

endmodule

// ### verilog/dscl_regs.vh
/*
 * Constants of the DIP switch configuration loader: register offsets,
 * configuration word layout, memory block layout, bus responses and timing.
 * Assumes it is included by bare name and holds definitions only.
 */
`ifndef DSCL_REGS_VH
`define DSCL_REGS_VH

// ****************************************************************
// Register byte offsets on the register bus
// ****************************************************************
`define DSCL_ADDR_W 8
`define DSCL_REG_CFG 8'h00
`define DSCL_REG_STATUS 8'h04
`define DSCL_REG_SRC_LO 8'h08
`define DSCL_REG_SRC_HI 8'h0C
`define DSCL_REG_OWN_LO 8'h10
`define DSCL_REG_OWN_HI 8'h14

// ****************************************************************
// Configuration word layout (16 bits, first bit shifted in is bit 15)
// ****************************************************************
`define DSCL_CFG_WIDTH 16
`define DSCL_F_FILTER 15
`define DSCL_F_HALF 14
`define DSCL_F_SRC_MSB 13
`define DSCL_F_SRC_LSB 8
`define DSCL_F_RATE_HI 7
`define DSCL_F_RATE_LO 6
`define DSCL_F_OWN_MSB 5
`define DSCL_F_OWN_LSB 0

// ****************************************************************
// Setting bits in the upper word of the occupied memory block
// ****************************************************************
`define DSCL_MB_FILTER 15
`define DSCL_MB_SRC_MSB 14
`define DSCL_MB_SRC_LSB 9
`define DSCL_MB_HALF 8

// ****************************************************************
// Status register fields and rate codes in Mbps
// ****************************************************************
`define DSCL_ST_DONE 0
`define DSCL_ST_BUSY 1
`define DSCL_ST_RATE_INV 2
`define DSCL_ST_RATE_LSB 4
`define DSCL_RATE_12 4'hC
`define DSCL_RATE_6 4'h6
`define DSCL_RATE_3 4'h3
`define DSCL_RATE_NONE 4'h0

// ****************************************************************
// Bus responses and serial timing
// ****************************************************************
`define DSCL_RESP_OKAY 2'h0
`define DSCL_RESP_SLVERR 2'h2
`define DSCL_CLK_MHZ 100
`define DSCL_SCLK_HALF_NS 500
`define DSCL_SCLK_HALF_CYC \
  ((`DSCL_SCLK_HALF_NS * `DSCL_CLK_MHZ + 999) / 1000)

`endif

// ### verilog/dscl_shifter.v
/*
 * Serial reader for the switch-reader chip: one load pulse, then a
 * configuration word shifted in most significant bit first.
 * Assumes the reader chip presents each bit before the rising edge of the
 * serial clock and that switch inputs are synchronous to MCLK.
 */
`timescale 1ns/1ps
`include "dscl_regs.vh"

module dscl_shifter #(
  parameter WIDTH = `DSCL_CFG_WIDTH,
  parameter HALF = `DSCL_SCLK_HALF_CYC
) (
  // Clock and reset
  input wire mclk,
  input wire nrst,
  // Switch reader pins
  input wire sw_data,
  output reg sw_clk_q,
  output reg sw_load_n_q,
  // Captured word
  output reg [WIDTH-1:0] word_q,
  output reg done_q,
  output reg busy_q
);

  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_LOAD = 2'h1;
  localparam [1:0] ST_SHIFT = 2'h2;
  localparam [1:0] ST_DONE = 2'h3;
  localparam integer HALF_M1_I = HALF - 1;
  localparam integer LAST_BIT_I = WIDTH - 1;
  // Counters are 16 and 8 bits wide; the constants are cut to match
  localparam [15:0] HALF_M1 = HALF_M1_I[15:0];
  localparam [7:0] LAST_BIT = LAST_BIT_I[7:0];

  reg [1:0] state_q;
  reg [15:0] cnt_q;
  reg [7:0] bit_q;
  wire tick;

  assign tick = (cnt_q == HALF_M1);

  // ****************************************************************
  // Sequencer: starts by itself once reset is released
  // ****************************************************************
  // The read runs exactly once per reset, so no restart path exists
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      cnt_q <= 16'h0000;
      bit_q <= 8'h00;
      sw_clk_q <= 1'b0;
      sw_load_n_q <= 1'b1;
      word_q <= {WIDTH{1'b0}};
      done_q <= 1'b0;
      busy_q <= 1'b0;
    end else begin
      cnt_q <= tick ? 16'h0000 : cnt_q + 16'h0001;
      case (state_q)
        ST_IDLE: begin
          state_q <= ST_LOAD;
          busy_q <= 1'b1;
          sw_load_n_q <= 1'b0;
          cnt_q <= 16'h0000;
        end
        ST_LOAD: begin
          if (tick) begin
            sw_load_n_q <= 1'b1;
            state_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (tick) begin
            sw_clk_q <= ~sw_clk_q;
            if (!sw_clk_q) begin
              // Closed switch pulls low, so low reads as one
              word_q <= {word_q[WIDTH-2:0], ~sw_data};
            end else if (bit_q == LAST_BIT) begin
              state_q <= ST_DONE;
            end else begin
              bit_q <= bit_q + 8'h01;
            end
          end
        end
        ST_DONE: begin
          done_q <= 1'b1;
          busy_q <= 1'b0;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule
